/* File: hdl/pasc_top.sv */
// Purpose: digital side of a pipelined 12-bit converter output stage
// Assumes: quantised code arrives each clock from the analog front end
// Notes:   outputs use separate data and enable signals, no tristate
`timescale 1ns/100ps
`default_nettype none
`include "pasc_regs.svh"
// Function
// - one sample taken each rising clock, one word delivered per clock
// - each word appears six clocks after its sample edge
// - result is a 12-bit word of positive minus negative input
// - differential coding is offset binary, 000 / 800 / FFF
// - single-ended coding is the same offset binary
// - sleep request high puts converter into low-power state
// - control inputs: clock, clock enable, reset, output enable, sleep request
// - output enable high releases data pins, conversion continues
// - words during and from sleep are corrupt and never valid
module pasc_top #(
    parameter int LATENCY    = `PASC_LATENCY,
    parameter int FIFO_DEPTH = `PASC_FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic       out_enable_n,
    input  wire logic       sleep_request,
    input  wire pasc_pkg::pasc_word_t sample_code,
    output pasc_pkg::pasc_word_t      data_out,
    output logic            data_oe,
    output logic            word_valid,
    input  wire logic       word_ready,
    output logic            fifo_ready,
    output logic            sleeping
);
    import pasc_pkg::*;
    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic       rst_meta_reg;
    logic       rst_n;
    logic [1:0] oe_sync_reg;
    logic [1:0] slp_sync_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end
    // out_enable_n and sleep_request are synchronised here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_sync_reg  <= 2'h3;
            slp_sync_reg <= 2'h0;
        end else if (clk_en) begin
            oe_sync_reg  <= {oe_sync_reg[0], out_enable_n};
            slp_sync_reg <= {slp_sync_reg[0], sleep_request};
        end
    end
    wire oe_n_s;
    wire sleep_s;
    assign oe_n_s  = oe_sync_reg[1];
    assign sleep_s = slp_sync_reg[1];
    // ------------------------------------------------------------
    // conversion pipeline
    // ------------------------------------------------------------
    pasc_sample_s pipe_reg [LATENCY];
    pasc_sample_s stage_in;
    // sleep poisons the sample entering and everything in flight
    assign stage_in.valid = !sleep_s;
    assign stage_in.code  = sleep_s ? `PASC_CODE_UNDEF : sample_code;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_reg[i] <= '0;
            end
        end else if (clk_en) begin
            pipe_reg[0] <= stage_in;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_reg[i].code  <= pipe_reg[i-1].code;
                pipe_reg[i].valid <= pipe_reg[i-1].valid && !sleep_s;
            end
        end
    end
    // code passes untouched: front end already yields offset binary
    pasc_sample_s head;
    assign head = pipe_reg[LATENCY-1];
    // ------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `PASC_CODE_UNDEF;
            sleeping <= 1'b0;
        end else if (clk_en) begin
            data_out <= head.code;
            sleeping <= sleep_s;
        end
    end
    // enable stays combinational; conversion ignores it
    assign data_oe = !oe_n_s;
    // ------------------------------------------------------------
    // capture buffer, fed only with trusted words
    // ------------------------------------------------------------
    wire push_ok;
    assign push_ok = head.valid && !oe_n_s && !sleep_s;
    pasc_fifo #(
        .WIDTH (`PASC_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .ce        (clk_en),
        .in_valid  (push_ok),
        .in_ready  (fifo_ready),
        .in_data   (head.code),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  ()
    );
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // the word at the head was sampled six cycles back, so the whole
    // window including that sampling cycle must be awake
    sequence awake_run;
        !sleep_s [*7];
    endsequence
    latency_six_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en [*7]) |-> data_out == $past(stage_in.code, 7))
        else $error("data latency wrong");
    word_rate_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en |=> pipe_reg[0] == $past(stage_in))
        else $error("sample not taken");
    sleep_poison_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && sleep_s |=> !pipe_reg[LATENCY-1].valid)
        else $error("word valid in sleep");
    sleep_flag_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en |=> sleeping == $past(sleep_s))
        else $error("sleep flag stale");
    oe_release_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        oe_n_s |-> !data_oe)
        else $error("pins driven while off");
    push_guard_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        push_ok |-> !oe_n_s && !sleep_s)
        else $error("bad word pushed");
    wake_skip_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(sleep_s) |-> !push_ok [*6])
        else $error("early word after sleep");
    code_width_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && !sleep_s) |=> pipe_reg[0].code == $past(sample_code))
        else $error("code altered");
    mid_code_a : assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en [*7]) and awake_run |->
        (head.code == `PASC_CODE_MID) == ($past(sample_code, 6) ==
        `PASC_CODE_MID))
        else $error("offset code changed");
endmodule : pasc_top
`default_nettype wire

/* File: hdl/pasc_regs.svh */
// Purpose: named constants for the pipelined converter output block
// Assumes: included by bare name
// Notes:   latency is in conversion clock cycles, fifo depth in words
`ifndef PASC_REGS_SVH
`define PASC_REGS_SVH
`define PASC_WORD_W      12
`define PASC_LATENCY     6
`define PASC_FIFO_DEPTH  16
`define PASC_CODE_NEG_FS 12'h000
`define PASC_CODE_MID    12'h800
`define PASC_CODE_POS_FS 12'hFFF
`define PASC_CODE_UNDEF  12'h000
`endif

/* File: hdl/pasc_pkg.sv */
// Purpose: shared types of the converter output block
// Assumes: pasc_regs.svh constants
// Notes:   none
`include "pasc_regs.svh"
package pasc_pkg;
    typedef logic [`PASC_WORD_W-1:0] pasc_word_t;
    typedef struct packed {
        logic       valid;
        pasc_word_t code;
    } pasc_sample_s;
endpackage : pasc_pkg

/* File: hdl/pasc_fifo.sv */
// Purpose: small synchronous fifo in the sample path
// Assumes: single clock, clock enable freezes all state
// Notes:   read data come out of a register
`timescale 1ns/100ps
`default_nettype none
module pasc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             oval_reg;
    wire              push;
    wire              pop;
    wire              load;
    wire              empty;
    assign empty     = (cnt_reg == '0);
    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign push      = in_valid && in_ready;
    // output register refills when empty or being taken
    assign load      = !empty && (!oval_reg || out_ready);
    assign pop       = oval_reg && out_ready;
    assign out_valid = oval_reg;
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_reg] <= in_data;
        end
        if (ce && load) begin
            out_data <= mem[rd_reg];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg   <= '0;
            rd_reg   <= '0;
            cnt_reg  <= '0;
            oval_reg <= 1'b0;
        end else if (ce) begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (load) rd_reg <= rd_reg + 1'b1;
            cnt_reg  <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
            if (load) oval_reg <= 1'b1;
            else if (pop) oval_reg <= 1'b0;
        end
    end
endmodule : pasc_fifo
`default_nettype wire

/* File: verification/pasc_capture.sv */
// Purpose: capture model latching words from the converter
// Assumes: stall is driven by the bench
// Notes:   released pins show the inverted last word
`timescale 1ns/100ps
`default_nettype none
module pasc_capture (
    input  wire logic       core_clk,
    input  wire pasc_pkg::pasc_word_t data_out,
    input  wire logic       data_oe,
    input  wire logic       word_valid,
    input  wire logic       stall,
    output logic            word_ready,
    output var int          taken
);
    import pasc_pkg::*;
    pasc_word_t last_reg = '0;
    pasc_word_t pins;
    // undriven pins must not look like a held word
    assign pins       = data_oe ? data_out : ~last_reg;
    assign word_ready = !stall;
    initial taken = 0;
    always @(negedge core_clk) begin
        last_reg <= pins;
    end
    always @(posedge core_clk) begin
        if (word_valid === 1'b1 && word_ready) taken <= taken + 1;
    end
endmodule : pasc_capture
`default_nettype wire

/* File: verification/test_pipelined_adc_sample_output.sv */
// Purpose: self-checking bench of the converter output block
// Assumes: inputs change on the falling clock edge
// Notes:   data_out carries a sample six edges after it is taken
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_adc_sample_output;
    import pasc_pkg::*;
    logic core_clk = 0, resetn = 0, clk_en = 1, stall = 1;
    logic out_enable_n = 0, sleep_request = 0;
    logic data_oe, word_valid, word_ready, fifo_ready, sleeping;
    pasc_word_t sample_code = '0, data_out;
    int taken, n, num_errors = 0, num_checks = 0;
    pasc_word_t codes[5] = '{12'h000, 12'h400, 12'h800, 12'hC00, 12'hFFF};
    always #25 core_clk = ~core_clk;
    pasc_top i_pasc_top(.core_clk(core_clk), .resetn(resetn),
        .clk_en(clk_en), .out_enable_n(out_enable_n),
        .sleep_request(sleep_request), .sample_code(sample_code),
        .data_out(data_out), .data_oe(data_oe), .word_valid(word_valid),
        .word_ready(word_ready), .fifo_ready(fifo_ready),
        .sleeping(sleeping));
    pasc_capture i_pasc_capture(.core_clk(core_clk), .data_out(data_out),
        .data_oe(data_oe), .word_valid(word_valid), .stall(stall),
        .word_ready(word_ready), .taken(taken));
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic stream_words;
        for (int j = 0; j < 13; j++) begin
            @(negedge core_clk);
            if (j >= 7) check(data_out, codes[(j-7)%5]);
            sample_code = codes[j%5];
        end
    endtask : stream_words
    // far side stalls until the fifo refuses, then drains with pins off
    task automatic fill_drain;
        n = 0;
        while (fifo_ready === 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        check(12'(fifo_ready), 12'h0);
        out_enable_n = 1;
        stall = 0;
        repeat (40) @(negedge core_clk);
        check(12'(word_valid), 12'h0);
        check(12'(data_oe), 12'h0);
        check(12'(taken >= 16), 12'h1);
        out_enable_n = 0;
    endtask : fill_drain
    task automatic sleep_cycle;
        sleep_request = 1;
        repeat (3) @(negedge core_clk);
        check(12'(sleeping), 12'h1);
        check(12'(data_oe), 12'h1);
        repeat (10) begin
            @(negedge core_clk);
            check(12'(word_valid), 12'h0);
        end
        sleep_request = 0;
        n = 0;
        while (word_valid !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        check(12'(n >= 8 && n < 40), 12'h1);
    endtask : sleep_cycle
    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (6) @(negedge core_clk);
        resetn = 1;
        repeat (3) @(negedge core_clk);
        stream_words;
        fill_drain;
        sleep_cycle;
        end_of_test;
    end
endmodule : test_pipelined_adc_sample_output
`default_nettype wire
